/* File: pixel_config_addressing.v */
// Functional notes
// R1: count full-FIFO write attempts, two per register
// R2: pixel byte: enable, inject, hitbus, trim, bit7
// R3: cleared enable suppresses digital hit output; in the power-bit variant it also cuts power (R4)
// R4: power-bit variant: zero cuts power and output
// R5: record quad address: column, row, region
// R6: four charge durations follow, left-most first
// R7: column select: core column, region bit, pair
// R8: row select: core row, upper region bits
// R9: configuration addresses pixel pairs, 17 bits
// R10: global configuration in corrected triple storage
// R11: counters triplicated with majority vote
// R13: counters saturate, reset clears, reads harmless
`timescale 1ns/100ps
`include "pixel_config_addressing_map.vh"

module pixel_config_addressing #(
  parameter ADDR_W  = 12,
  parameter PAIR_AW = 17,
  parameter FIFOS   = 8,
  parameter [1:0] FLAVOR = 2'd0
) (
  input  wire                i_clk,
  input  wire                i_rst,
  input  wire [ADDR_W-1:0]   i_awaddr,
  input  wire                i_awvalid,
  output wire                o_awready,
  input  wire [31:0]         i_wdata,
  input  wire [3:0]          i_wstrb,
  input  wire                i_wvalid,
  output wire                o_wready,
  output wire [1:0]          o_bresp,
  output wire                o_bvalid,
  input  wire                i_bready,
  input  wire [ADDR_W-1:0]   i_araddr,
  input  wire                i_arvalid,
  output wire                o_arready,
  output wire [31:0]         o_rdata,
  output wire [1:0]          o_rresp,
  output wire                o_rvalid,
  input  wire                i_rready,
  input  wire [FIFOS-1:0]    i_fifo_wr,
  input  wire [FIFOS-1:0]    i_fifo_full,
  input  wire                i_hit_valid,
  input  wire [15:0]         i_hit_quad,
  input  wire [15:0]         i_hit_dur,
  output wire                o_rec_valid,
  output wire [31:0]         o_rec_data,
  output wire [1:0]          o_pair_power,
  output wire [1:0]          o_pair_inject,
  output wire [1:0]          o_pair_hitbus,
  output wire [7:0]          o_pair_trim,
  output wire [1:0]          o_pair_trim_sign,
  output wire [1:0]          o_pair_gain,
  output wire                o_irq
);

  function [15:0] maj;
    input [15:0] a;
    input [15:0] b;
    input [15:0] c;
    begin
      maj = (a & b) | (a & c) | (b & c);
    end
  endfunction

  // pair index {core col, region[0], pair, core row, region[3:1]}
  function [16:0] pidx;
    input [5:0] col;
    input [5:0] row;
    input [3:0] region;
    input       pair;
    begin
      pidx = {col, region[0], pair, row, region[3:1]};
    end
  endfunction

  function [7:0] widx;
    input [ADDR_W-1:0] addr;
    begin
      widx = addr[9:2];
    end
  endfunction

  // ---------------- bus handshake ----------------
  reg               awready_q;
  reg               wready_q;
  reg               bvalid_q;
  reg  [1:0]        bresp_q;
  reg               arready_q;
  reg               rvalid_q;
  reg  [31:0]       rdata_q;
  reg  [1:0]        rresp_q;
  reg               aw_got_q;
  reg               w_got_q;
  reg  [ADDR_W-1:0] awaddr_q;
  reg  [31:0]       wdata_q;
  reg  [3:0]        wstrb_q;

  wire aw_hs = i_awvalid & awready_q;
  wire w_hs  = i_wvalid & wready_q;
  wire ar_hs = i_arvalid & arready_q;
  wire do_wr = aw_got_q & w_got_q & ~bvalid_q;
  wire [7:0] wr_idx = widx(awaddr_q);
  wire [7:0] rd_idx = widx(i_araddr);
  wire wr_hit = (awaddr_q[1:0] == 2'b00) && (awaddr_q[ADDR_W-1:10] == 0);
  wire rd_hit = (i_araddr[1:0] == 2'b00) && (i_araddr[ADDR_W-1:10] == 0);

  wire wr_col  = do_wr & wr_hit & (wr_idx == `IDX_PIXEL_COLUMN_SELECT);
  wire wr_row  = do_wr & wr_hit & (wr_idx == `IDX_PIXEL_ROW_SELECT);
  wire wr_pix  = do_wr & wr_hit & (wr_idx == `IDX_PIXEL_SETUP_BYTE);
  wire wr_ien  = do_wr & wr_hit & (wr_idx == `IDX_IRQ_ENABLE);
  wire wr_iclr = do_wr & wr_hit & (wr_idx == `IDX_IRQ_CLEAR);
  wire wr_ok   = wr_col | wr_row | wr_pix | wr_ien | wr_iclr;

  // ---------------- global configuration, triple stored ----------------
  reg  [7:0] col_q [0:2];
  reg  [8:0] row_q [0:2];
  reg  [7:0] ien_q [0:2];
  wire [15:0] col_m = maj({8'h00, col_q[0]}, {8'h00, col_q[1]}, {8'h00, col_q[2]});
  wire [15:0] row_m = maj({7'h00, row_q[0]}, {7'h00, row_q[1]}, {7'h00, row_q[2]});
  wire [15:0] ien_m = maj({8'h00, ien_q[0]}, {8'h00, ien_q[1]}, {8'h00, ien_q[2]});
  wire [7:0]  col_v = col_m[7:0];
  wire [8:0]  row_v = row_m[8:0];
  wire [7:0]  ien_v = ien_m[7:0];

  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : g_cfg
      // every copy is rewritten from the vote, so a single upset is scrubbed
      always @(posedge i_clk or posedge i_rst) begin // R10
        if (i_rst) begin
          col_q[k] <= `RST_COLUMN_SELECT;
          row_q[k] <= `RST_ROW_SELECT;
          ien_q[k] <= `RST_IRQ_ENABLE;
        end else begin
          col_q[k] <= (wr_col & wstrb_q[0]) ? wdata_q[7:0] : col_v; // R7
          row_q[k] <= wr_row ? {(wstrb_q[1] ? wdata_q[8] : row_v[8]),
                                (wstrb_q[0] ? wdata_q[7:0] : row_v[7:0])} : row_v; // R8
          ien_q[k] <= (wr_ien & wstrb_q[0]) ? wdata_q[7:0] : ien_v;
        end
      end
    end
  endgenerate

  // ---------------- pixel configuration, plain storage ----------------
  localparam DEPTH = 1 << PAIR_AW;
  reg  [15:0] pix_mem [0:DEPTH-1];
  wire [16:0] cfg_full = {col_v, row_v}; // R9
  wire [PAIR_AW-1:0] cfg_idx = cfg_full[PAIR_AW-1:0];
  wire [15:0] cfg_pair = pix_mem[cfg_idx];

  always @(posedge i_clk) begin
    if (wr_pix) begin // R9 R10
      if (wstrb_q[0]) pix_mem[cfg_idx][7:0] <= wdata_q[7:0];
      if (wstrb_q[1]) pix_mem[cfg_idx][15:8] <= wdata_q[15:8];
    end
  end

  // ---------------- full-write counters, triplicated ----------------
  reg  [7:0] cnt_q [0:3*FIFOS-1];
  wire [7:0] cnt_v [0:FIFOS-1];
  wire [FIFOS-1:0] ovf_evt = i_fifo_wr & i_fifo_full; // R1

  genvar f;
  generate
    for (f = 0; f < FIFOS; f = f + 1) begin : g_cnt
      wire [15:0] m = maj({8'h00, cnt_q[f]}, {8'h00, cnt_q[FIFOS+f]},
                          {8'h00, cnt_q[2*FIFOS+f]});
      assign cnt_v[f] = m[7:0]; // R11
      for (k = 0; k < 3; k = k + 1) begin : g_copy
        always @(posedge i_clk or posedge i_rst) begin
          if (i_rst)
            cnt_q[k*FIFOS+f] <= `RST_COUNTER; // R13
          else if (ovf_evt[f] && cnt_v[f] != 8'hff)
            cnt_q[k*FIFOS+f] <= cnt_v[f] + 8'h01; // R1 R13
          else
            cnt_q[k*FIFOS+f] <= cnt_v[f]; // R11
        end
      end
    end
  endgenerate

  // ---------------- interrupt status ----------------
  reg  [7:0] ist_q;
  reg        irq_q;
  wire [7:0] ovf8 = ovf_evt[7:0];

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ist_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      // a new event in the clearing cycle keeps its bit
      ist_q <= (ist_q & ~(wr_iclr && wstrb_q[0] ? wdata_q[7:0] : 8'h00)) | ovf8;
      irq_q <= |(ist_q & ien_v);
    end
  end

  // ---------------- write channel ----------------
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      awaddr_q  <= {ADDR_W{1'b0}};
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
    end else begin
      if (aw_hs) begin
        awaddr_q  <= i_awaddr;
        aw_got_q  <= 1'b1;
        awready_q <= 1'b0;
      end else if (~aw_got_q & ~bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (w_hs) begin
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
        w_got_q  <= 1'b1;
        wready_q <= 1'b0;
      end else if (~w_got_q & ~bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q & i_bready) begin
        bvalid_q <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
      end
    end
  end

  // ---------------- read channel ----------------
  reg  [31:0] rd_d;
  reg         rd_ok;

  always @* begin
    rd_d  = 32'h00000000;
    rd_ok = rd_hit;
    case (rd_idx)
      `IDX_PIXEL_COLUMN_SELECT: rd_d = {24'h000000, col_v};
      `IDX_PIXEL_ROW_SELECT:    rd_d = {23'h000000, row_v};
      `IDX_PIXEL_SETUP_BYTE:    rd_d = {16'h0000, cfg_pair};
      `IDX_FIFO_OVERFLOW_01:    rd_d = {16'h0000, cnt_v[1], cnt_v[0]}; // R1
      `IDX_FIFO_OVERFLOW_23:    rd_d = {16'h0000, cnt_v[3], cnt_v[2]}; // R1
      `IDX_FIFO_OVERFLOW_45:    rd_d = {16'h0000, cnt_v[5], cnt_v[4]}; // R1
      `IDX_FIFO_OVERFLOW_67:    rd_d = {16'h0000, cnt_v[7], cnt_v[6]}; // R1
      `IDX_IRQ_STATUS:          rd_d = {24'h000000, ist_q};
      `IDX_IRQ_ENABLE:          rd_d = {24'h000000, ien_v};
      `IDX_IRQ_CLEAR:           rd_d = 32'h00000000;
      default:                  rd_ok = 1'b0;
    endcase
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `RESP_OKAY;
    end else begin
      if (ar_hs) begin
        // reading never disturbs a counter
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_ok ? rd_d : 32'h00000000; // R13
        rresp_q   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_q & i_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end else if (~rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  // ---------------- addressed pair controls ----------------
  reg  [1:0] pwr_q;
  reg  [1:0] inj_q;
  reg  [1:0] hb_q;
  reg  [7:0] trim_q;
  reg  [1:0] sign_q;
  reg  [1:0] gain_q;
  wire       has_trim = (FLAVOR != `FE_SYNC);

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pwr_q  <= 2'b00;
      inj_q  <= 2'b00;
      hb_q   <= 2'b00;
      trim_q <= 8'h00;
      sign_q <= 2'b00;
      gain_q <= 2'b00;
    end else begin
      pwr_q  <= (FLAVOR == `FE_LIN) ? {cfg_pair[8], cfg_pair[0]} : 2'b11; // R4
      inj_q  <= {cfg_pair[8+`PIX_INJECT_EN], cfg_pair[`PIX_INJECT_EN]}; // R2
      hb_q   <= {cfg_pair[8+`PIX_HITBUS_EN], cfg_pair[`PIX_HITBUS_EN]}; // R2
      trim_q <= has_trim ? {cfg_pair[8+`PIX_TRIM_HI:8+`PIX_TRIM_LO],
                            cfg_pair[`PIX_TRIM_HI:`PIX_TRIM_LO]} : 8'h00; // R2
      sign_q <= (FLAVOR == `FE_DIFF) ? {cfg_pair[15], cfg_pair[7]} : 2'b00; // R2
      gain_q <= (FLAVOR == `FE_LIN) ? {cfg_pair[15], cfg_pair[7]} : 2'b00; // R2
    end
  end

  // ---------------- data records ----------------
  wire [5:0]  h_col = i_hit_quad[`QUAD_COL_HI:`QUAD_COL_LO];
  wire [5:0]  h_row = i_hit_quad[`QUAD_ROW_HI:`QUAD_ROW_LO];
  wire [3:0]  h_reg = i_hit_quad[`QUAD_REG_HI:`QUAD_REG_LO];
  wire [16:0] l_full = pidx(h_col, h_row, h_reg, 1'b0);
  wire [16:0] r_full = pidx(h_col, h_row, h_reg, 1'b1);
  wire [15:0] l_pair = pix_mem[l_full[PAIR_AW-1:0]];
  wire [15:0] r_pair = pix_mem[r_full[PAIR_AW-1:0]];
  // bit 0 gates the digital result; in the FE_LIN variant it also drives o_pair_power
  wire [3:0]  en = {r_pair[8], r_pair[0], l_pair[8], l_pair[0]}; // R3 R4
  reg         rec_valid_q;
  reg  [31:0] rec_data_q;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rec_valid_q <= 1'b0;
      rec_data_q  <= 32'h00000000;
    end else begin
      rec_valid_q <= i_hit_valid;
      if (i_hit_valid)
        rec_data_q <= {i_hit_quad, // R5
                       i_hit_dur[3:0] & {4{en[0]}},
                       i_hit_dur[7:4] & {4{en[1]}},
                       i_hit_dur[11:8] & {4{en[2]}},
                       i_hit_dur[15:12] & {4{en[3]}}}; // R6 R3
    end
  end

  assign o_awready        = awready_q;
  assign o_wready         = wready_q;
  assign o_bvalid         = bvalid_q;
  assign o_bresp          = bresp_q;
  assign o_arready        = arready_q;
  assign o_rvalid         = rvalid_q;
  assign o_rdata          = rdata_q;
  assign o_rresp          = rresp_q;
  assign o_rec_valid      = rec_valid_q;
  assign o_rec_data       = rec_data_q;
  assign o_pair_power     = pwr_q;
  assign o_pair_inject    = inj_q;
  assign o_pair_hitbus    = hb_q;
  assign o_pair_trim      = trim_q;
  assign o_pair_trim_sign = sign_q;
  assign o_pair_gain      = gain_q;
  assign o_irq            = irq_q;

endmodule

/* File: pixel_config_addressing_map.vh */
`ifndef PIXEL_CONFIG_ADDRESSING_MAP_VH
`define PIXEL_CONFIG_ADDRESSING_MAP_VH

// register indices; byte address is four times the index
`define IDX_PIXEL_COLUMN_SELECT   8'h01
`define IDX_PIXEL_ROW_SELECT      8'h02
`define IDX_PIXEL_SETUP_BYTE      8'h03
`define IDX_FIFO_OVERFLOW_01      8'h7c
`define IDX_FIFO_OVERFLOW_23      8'h7d
`define IDX_FIFO_OVERFLOW_45      8'h7e
`define IDX_FIFO_OVERFLOW_67      8'h7f
`define IDX_IRQ_STATUS            8'h10
`define IDX_IRQ_ENABLE            8'h11
`define IDX_IRQ_CLEAR             8'h12

// reset values
`define RST_COLUMN_SELECT         8'h00
`define RST_ROW_SELECT            9'h000
`define RST_IRQ_ENABLE            8'h00
`define RST_COUNTER               8'h00
`define RST_PIXEL_BYTE            8'h00

// pixel setup byte fields
`define PIX_OUT_EN                0
`define PIX_INJECT_EN             1
`define PIX_HITBUS_EN             2
`define PIX_TRIM_LO               3
`define PIX_TRIM_HI               6
`define PIX_BIT7                  7

// column select fields
`define COL_CORE_HI               7
`define COL_CORE_LO               2
`define COL_REGION0               1
`define COL_PAIR                  0

// row select fields
`define ROW_CORE_HI               8
`define ROW_CORE_LO               3
`define ROW_REGION_HI             2
`define ROW_REGION_LO             0

// quad address fields in a data record
`define QUAD_COL_HI               15
`define QUAD_COL_LO               10
`define QUAD_ROW_HI               9
`define QUAD_ROW_LO               4
`define QUAD_REG_HI               3
`define QUAD_REG_LO               0

// front-end variants
`define FE_DIFF                   2'd0
`define FE_LIN                    2'd1
`define FE_SYNC                   2'd2

// bus answers
`define RESP_OKAY                 2'b00
`define RESP_SLVERR               2'b10

`endif

/* File: pixel_config_addressing_properties.sv */
`timescale 1ns/100ps
module pixel_config_props #(
  parameter [1:0] FLAVOR = 2'd0
) (
  input wire        i_clk,
  input wire        i_rst,
  input wire        i_awvalid,
  input wire        o_awready,
  input wire        i_wvalid,
  input wire        o_wready,
  input wire        o_bvalid,
  input wire        i_arvalid,
  input wire        o_arready,
  input wire        o_rvalid,
  input wire        i_hit_valid,
  input wire [15:0] i_hit_quad,
  input wire [15:0] i_hit_dur,
  input wire        o_rec_valid,
  input wire [31:0] o_rec_data,
  input wire [1:0]  o_pair_power,
  input wire [1:0]  o_pair_gain
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_hit; i_hit_valid; endsequence
  sequence s_wr_taken; i_awvalid && o_awready && i_wvalid && o_wready; endsequence
  sequence s_rd_taken; i_arvalid && o_arready; endsequence
  property p_rec_pulse; s_hit |=> o_rec_valid; endproperty
  property p_rec_quiet; !i_hit_valid |=> !o_rec_valid; endproperty
  property p_rec_quad; s_hit |=> o_rec_data[31:16] == $past(i_hit_quad); endproperty
  property p_rec_first;
    s_hit |=> o_rec_data[15:12] == $past(i_hit_dur[3:0]) || o_rec_data[15:12] == 4'h0;
  endproperty
  property p_rd_answer; s_rd_taken |=> o_rvalid; endproperty
  property p_rd_busy; s_rd_taken |=> !o_arready ##1 (o_arready != o_rvalid); endproperty
  property p_wr_answer; s_wr_taken |-> ##[1:2] o_bvalid; endproperty
  property p_wr_busy; s_wr_taken |=> (!o_awready && !o_wready) [*2]; endproperty
  // analog side stays powered unless the power-bit variant is built
  property p_power; FLAVOR != 2'd1 && !$past(i_rst) |-> o_pair_power == 2'b11; endproperty
  property p_gain; FLAVOR == 2'd0 |-> o_pair_gain == 2'b00; endproperty
  a_rec_pulse:
    assert property (p_rec_pulse) else $error("no record after hit");
  a_rec_quiet:
    assert property (p_rec_quiet) else $error("record without hit");
  a_rec_quad:
    assert property (p_rec_quad) else $error("record quad address wrong");
  a_rec_first:
    assert property (p_rec_first) else $error("left-most duration misplaced");
  a_rd_answer:
    assert property (p_rd_answer) else $error("read not answered");
  a_rd_busy:
    assert property (p_rd_busy) else $error("read address ready too early");
  a_wr_answer:
    assert property (p_wr_answer) else $error("write not answered");
  a_wr_busy:
    assert property (p_wr_busy) else $error("write ready too early");
  a_power:
    assert property (p_power) else $error("pixel power dropped");
  a_gain:
    assert property (p_gain) else $error("gain set in trim-sign variant");
endmodule

bind pixel_config_addressing pixel_config_props #(.FLAVOR(FLAVOR)) pixel_config_props_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rvalid(o_rvalid), .i_hit_valid(i_hit_valid),
  .i_hit_quad(i_hit_quad), .i_hit_dur(i_hit_dur), .o_rec_valid(o_rec_valid),
  .o_rec_data(o_rec_data), .o_pair_power(o_pair_power), .o_pair_gain(o_pair_gain));

/* File: fifo_side_model.sv */
`timescale 1ns/100ps
module fifo_side_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_start,
  input  wire logic [7:0] i_sel,
  input  wire logic [8:0] i_count,
  output logic      [7:0] o_wr,
  output logic      [7:0] o_full,
  output logic            o_busy
);
  logic [8:0] left_q;
  logic       skip_q;
  assign o_busy = left_q != 9'h000;
  // full stays up between attempts; fifo 0 is written on every attempt but full only if i_sel selects it
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      left_q <= 9'h000;
      skip_q <= 1'b0;
      o_wr <= 8'h00;
      o_full <= 8'h00;
    end else begin
      skip_q <= ~skip_q;
      o_wr <= 8'h00;
      if (i_start) begin
        left_q <= i_count;
        o_full <= i_sel;
      end else if (o_busy && !skip_q) begin
        o_wr <= i_sel | 8'h01;
        left_q <= left_q - 9'h001;
      end
    end
  end
endmodule

/* File: tb_pixel_config_addressing.sv */
`timescale 1ns/100ps
`include "pixel_config_addressing_map.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb_pixel_config_addressing;
  typedef struct {logic [11:0] a; logic [31:0] d, r; logic [1:0] wresp, rresp;} row_t;
  logic        i_clk = 0;
  logic        i_rst = 1;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, hv = 0, start = 0;
  logic [15:0] quad = 0, dur = 0;
  logic [7:0]  sel = 0;
  logic [8:0]  cnt = 0;
  wire  [7:0]  fwr, ffull, trim;
  wire  [31:0] rdata, rec;
  wire  [1:0]  bresp, rresp, pw, inj, hb, sg, gn;
  wire         awready, wready, bvalid, arready, rvalid, recv, irq, busy;
  int          mismatches = 0;
  int          total_checks = 0;
  row_t rows [8] = '{
    '{12'h004, 32'h1ff, 32'hff, `RESP_OKAY, `RESP_OKAY},
    '{12'h008, 32'hffff, 32'h1ff, `RESP_OKAY, `RESP_OKAY},
    '{12'h044, 32'hff, 32'hff, `RESP_OKAY, `RESP_OKAY},
    '{12'h048, 32'h1, 32'h0, `RESP_OKAY, `RESP_OKAY},
    '{12'h040, 32'hff, 32'h0, `RESP_SLVERR, `RESP_OKAY},
    '{12'h1f4, 32'hff, 32'h0, `RESP_SLVERR, `RESP_OKAY},
    '{12'h3f0, 32'h5, 32'h0, `RESP_SLVERR, `RESP_SLVERR},
    '{12'h006, 32'h5, 32'h0, `RESP_SLVERR, `RESP_SLVERR}};

  always #4 i_clk = ~i_clk;

  pixel_config_addressing #(.PAIR_AW(10)) pixel_config_addressing_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_fifo_wr(fwr), .i_fifo_full(ffull), .i_hit_valid(hv), .i_hit_quad(quad), .i_hit_dur(dur),
    .o_rec_valid(recv), .o_rec_data(rec), .o_pair_power(pw), .o_pair_inject(inj),
    .o_pair_hitbus(hb), .o_pair_trim(trim), .o_pair_trim_sign(sg), .o_pair_gain(gn), .o_irq(irq));

  fifo_side_model fifo_side_model_inst (.i_clk(i_clk), .i_rst(i_rst), .i_start(start),
    .i_sel(sel), .i_count(cnt), .o_wr(fwr), .o_full(ffull), .o_busy(busy));

  wire [1:0]  fe_pw [1:2], fe_sg [1:2], fe_gn [1:2];
  wire [7:0]  fe_trim [1:2];
  wire [31:0] fe_rec [1:2];

  // the other two front-end variants see the same traffic
  for (genvar v = 1; v < 3; v++) begin : g_fe
    pixel_config_addressing #(.PAIR_AW(10), .FLAVOR(2'(v))) pixel_config_addressing_inst (
      .i_clk(i_clk), .i_rst(i_rst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(),
      .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(), .o_bresp(),
      .o_bvalid(), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(),
      .o_rdata(), .o_rresp(), .o_rvalid(), .i_rready(rready), .i_fifo_wr(fwr),
      .i_fifo_full(ffull), .i_hit_valid(hv), .i_hit_quad(quad), .i_hit_dur(dur),
      .o_rec_valid(), .o_rec_data(fe_rec[v]), .o_pair_power(fe_pw[v]), .o_pair_inject(),
      .o_pair_hitbus(), .o_pair_trim(fe_trim[v]), .o_pair_trim_sign(fe_sg[v]),
      .o_pair_gain(fe_gn[v]), .o_irq());
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    `CHK({bvalid, bresp}, {1'b1, er})
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    `CHK({rvalid, rresp, rdata}, {1'b1, er, e})
    rready <= 1'b0;
  endtask

  task automatic feed(input logic [7:0] s, input logic [8:0] c);
    int n;
    n = 0;
    @(posedge i_clk);
    sel <= s;
    cnt <= c;
    start <= 1'b1;
    @(posedge i_clk);
    start <= 1'b0;
    repeat (2) @(posedge i_clk);
    while (busy && n < 2000) begin
      @(posedge i_clk);
      n++;
    end
    `CHK(busy, 1'b0)
    repeat (3) @(posedge i_clk);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    mismatches++;
    results();
  end

  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].wresp);
      rd(rows[i].a, rows[i].r, rows[i].rresp);
    end
    $display("register table done");
    wr(12'h004, 32'h0, `RESP_OKAY);
    wr(12'h008, 32'h0, `RESP_OKAY);
    // injection is armed here, while no hits are being sent
    wr(12'h00c, 32'h8d7a, `RESP_OKAY);
    rd(12'h00c, 32'h8d7a, `RESP_OKAY);
    @(negedge i_clk);
    `CHK({inj, hb, trim, sg, gn, pw}, {2'b01, 2'b10, 8'h1f, 2'b10, 2'b00, 2'b11})
    `CHK({fe_pw[1], fe_gn[1], fe_sg[1], fe_trim[1]}, {2'b10, 2'b10, 2'b00, 8'h1f})
    `CHK({fe_pw[2], fe_gn[2], fe_sg[2], fe_trim[2]}, {2'b11, 2'b00, 2'b00, 8'h00})
    wr(12'h004, 32'h1, `RESP_OKAY);
    wr(12'h00c, 32'h0101, `RESP_OKAY);
    $display("pixel setup done");
    // back-to-back hits; pixel 0 of the quad is disabled
    @(posedge i_clk);
    hv <= 1'b1;
    quad <= 16'h0000;
    dur <= 16'h4321;
    @(posedge i_clk);
    quad <= 16'h1400;
    dur <= 16'hfedc;
    @(negedge i_clk);
    `CHK({recv, rec}, {1'b1, 32'h0000_0234})
    `CHK({fe_rec[1], fe_rec[2]}, {2{32'h0000_0234}})
    @(posedge i_clk);
    hv <= 1'b0;
    @(negedge i_clk);
    `CHK({recv, rec}, {1'b1, 32'h1400_0def})
    @(negedge i_clk);
    `CHK(recv, 1'b0)
    $display("record test done");
    feed(8'h02, 9'd3);
    feed(8'h40, 9'd300);
    rd(12'h1f0, 32'h0300, `RESP_OKAY);
    rd(12'h1f0, 32'h0300, `RESP_OKAY);
    rd(12'h1fc, 32'h00ff, `RESP_OKAY);
    $display("counter test done");
    rd(12'h040, 32'h42, `RESP_OKAY);
    @(negedge i_clk);
    `CHK(irq, 1'b1)
    wr(12'h044, 32'h0, `RESP_OKAY);
    repeat (2) @(negedge i_clk);
    `CHK(irq, 1'b0)
    wr(12'h044, 32'h42, `RESP_OKAY);
    wr(12'h048, 32'h2, `RESP_OKAY);
    rd(12'h040, 32'h40, `RESP_OKAY);
    @(negedge i_clk);
    `CHK(irq, 1'b1)
    wr(12'h048, 32'h40, `RESP_OKAY);
    rd(12'h040, 32'h0, `RESP_OKAY);
    @(negedge i_clk);
    `CHK(irq, 1'b0)
    $display("interrupt test done");
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(12'h1fc, 32'h0, `RESP_OKAY);
    rd(12'h004, 32'h0, `RESP_OKAY);
    $display("reset test done");
    results();
  end
endmodule
